//--- rtl/line_control_pkg.sv
// shared constants and types of the line control block
package line_control_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 16;

  // register offset in the paged register space
  localparam logic [ADDR_W-1:0] LINE_CONTROL_OFFSET = 12'h112;

  // fixed identifier in the six low bits
  localparam logic [5:0] LINE_CONTROL_ID = 6'h13;

  // value after reset when no configuration memory is present
  localparam logic [DATA_W-1:0] LINE_CONTROL_RESET = 16'h0013;

  // read data for an unmapped offset
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 16'h0000;

  // register image, bit 15 down to bit 0
  typedef struct packed {
    logic spare_f;
    logic low_squelch_select;
    logic two_stage_defer_disable;
    logic polarity_fix_disable;
    logic modified_backoff;
    logic spare_a;
    logic auto_port_select;
    logic force_attachment_port;
    logic transmit_enable_bit;
    logic receive_enable_bit;
    logic [5:0] id;
  } line_control_s;

  // register access port
  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_s;

  // physical port choice
  typedef enum logic [1:0] {
    PORT_TWISTED = 2'h0,
    PORT_ATTACH = 2'h1,
    PORT_AUTO = 2'h2
  } port_mode_e;

endpackage : line_control_pkg

//--- rtl/frame_gate.sv
// lets a frame through only if enabled at its start, and never cuts it short
`timescale 1ns/10ps
`default_nettype none
module frame_gate (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // control
  input wire logic enable_i,
  input wire logic frame_i,
  // result
  output logic pass_o
);

  typedef struct packed {
    logic was_active;
    logic accepted;
  } gate_s;

  gate_s state;
  gate_s next_state;
  logic decision;

  // a frame in flight keeps the decision taken at its first cycle
  assign decision = state.was_active ? state.accepted : enable_i;
  assign pass_o = frame_i & decision;

  always_comb begin
    next_state = state;
    next_state.was_active = frame_i;
    next_state.accepted = frame_i ? decision : enable_i;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= '0;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

endmodule : frame_gate
`default_nettype wire

//--- rtl/ethernet_line_control.sv
// line control register and the receive, transmit and port selection it steers
// Operation
// - receive enable set passes incoming packets; clear passes none
// - clearing receive enable mid-packet finishes that packet, then blocks further ones
// - transmit enable set permits transmission; clear starts none
// - clearing transmit enable mid-packet completes it, then sends nothing more
// - bits 8 and 9 together select attachment or twisted-pair port
// - twisted-pair transmitter stays off without link pulses unless link test disabled
// - polarity correction applied unless the polarity fix disable bit is set
// - register resets to 0000 0000 0001 0011, enables and port selection clear
`timescale 1ns/10ps
`default_nettype none
module ethernet_line_control (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // register access
  input wire line_control_pkg::reg_req_s reg_req_i,
  output logic [line_control_pkg::DATA_W-1:0] reg_rdata_o,
  // receiver side of the mac engine
  input wire logic rx_frame_i,
  output logic rx_pass_o,
  // transmitter side of the mac engine
  input wire logic tx_frame_i,
  output logic tx_pass_o,
  // physical interface status
  input wire logic link_pulses_ok_i,
  input wire logic link_test_disable_i,
  input wire logic rx_polarity_reversed_i,
  // physical interface control
  output logic attach_port_sel_o,
  output logic twisted_port_sel_o,
  output logic twisted_tx_active_o,
  output logic polarity_invert_o,
  output logic low_squelch_o,
  output logic two_stage_defer_disable_o,
  output logic modified_backoff_o
);

  typedef struct packed {
    line_control_pkg::line_control_s ctl;
    logic [line_control_pkg::DATA_W-1:0] rdata;
    logic attach_sel;
    logic twisted_sel;
    logic twisted_tx;
    logic pol_invert;
  } state_s;

  state_s state;
  state_s next_state;
  line_control_pkg::port_mode_e port_mode;
  logic hit;
  logic link_up;

  assign hit = (reg_req_i.addr == line_control_pkg::LINE_CONTROL_OFFSET);
  assign link_up = link_pulses_ok_i | link_test_disable_i;

  // force bit wins over the auto bit
  always_comb begin
    if (state.ctl.force_attachment_port) begin
      port_mode = line_control_pkg::PORT_ATTACH;
    end else if (state.ctl.auto_port_select) begin
      port_mode = line_control_pkg::PORT_AUTO;
    end else begin
      port_mode = line_control_pkg::PORT_TWISTED;
    end
  end

  always_comb begin
    next_state = state;
    if (reg_req_i.wr && hit) begin
      next_state.ctl = line_control_pkg::line_control_s'(reg_req_i.wdata);
      // identifier and spare bits are not writable
      next_state.ctl.id = line_control_pkg::LINE_CONTROL_ID;
      next_state.ctl.spare_f = 1'b0;
      next_state.ctl.spare_a = 1'b0;
    end
    if (reg_req_i.rd) begin
      if (hit) begin
        next_state.rdata = state.ctl;
      end else begin
        next_state.rdata = line_control_pkg::UNMAPPED_READ;
      end
    end
    // auto mode falls back to attachment when the twisted pair shows no link
    case (port_mode)
      line_control_pkg::PORT_ATTACH: begin
        next_state.attach_sel = 1'b1;
        next_state.twisted_sel = 1'b0;
      end
      line_control_pkg::PORT_AUTO: begin
        next_state.attach_sel = ~link_pulses_ok_i;
        next_state.twisted_sel = link_pulses_ok_i;
      end
      default: begin
        next_state.attach_sel = 1'b0;
        next_state.twisted_sel = 1'b1;
      end
    endcase
    next_state.twisted_tx = next_state.twisted_sel & link_up;
    next_state.pol_invert = next_state.twisted_sel & rx_polarity_reversed_i
                            & ~state.ctl.polarity_fix_disable;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state.ctl <= line_control_pkg::LINE_CONTROL_RESET;
      state.rdata <= '0;
      state.attach_sel <= 1'b0;
      state.twisted_sel <= 1'b0;
      state.twisted_tx <= 1'b0;
      state.pol_invert <= 1'b0;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  // an enable cleared mid-frame takes effect at the next frame
  frame_gate u_rx_gate (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .enable_i(state.ctl.receive_enable_bit),
    .frame_i(rx_frame_i),
    .pass_o(rx_pass_o)
  );

  frame_gate u_tx_gate (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .enable_i(state.ctl.transmit_enable_bit),
    .frame_i(tx_frame_i),
    .pass_o(tx_pass_o)
  );

  assign reg_rdata_o = state.rdata;
  assign attach_port_sel_o = state.attach_sel;
  assign twisted_port_sel_o = state.twisted_sel;
  assign twisted_tx_active_o = state.twisted_tx;
  assign polarity_invert_o = state.pol_invert;
  assign low_squelch_o = state.ctl.low_squelch_select;
  assign two_stage_defer_disable_o = state.ctl.two_stage_defer_disable;
  assign modified_backoff_o = state.ctl.modified_backoff;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_READ_ID: assert property (ce_i && reg_req_i.rd && hit |=> reg_rdata_o[5:0] == line_control_pkg::LINE_CONTROL_ID)
    else $error("read of line control lost its identifier");
  AST_RX_IDLE_BLOCK: assert property (!rx_frame_i |-> !rx_pass_o)
    else $error("receive passed with no frame");
  AST_TX_IDLE_BLOCK: assert property (!tx_frame_i |-> !tx_pass_o)
    else $error("transmit permitted with no frame");
  AST_RX_BLOCKED_START: assert property ($rose(rx_frame_i) && !state.ctl.receive_enable_bit |-> !rx_pass_o)
    else $error("frame started while receive disabled");
  AST_RX_FINISH: assert property (rx_pass_o && rx_frame_i ##1 rx_frame_i && ce_i && $past(ce_i) |-> rx_pass_o)
    else $error("frame cut short in the receiver");
  AST_TX_BLOCKED_START: assert property ($rose(tx_frame_i) && !state.ctl.transmit_enable_bit |-> !tx_pass_o)
    else $error("transmission started while disabled");
  AST_TX_FINISH: assert property (tx_pass_o && ce_i ##1 tx_frame_i |-> tx_pass_o)
    else $error("transmission cut short");
  AST_PORT_FORCE: assert property (ce_i && state.ctl.force_attachment_port |=> attach_port_sel_o && !twisted_port_sel_o)
    else $error("force bit did not select attachment port");
  AST_PORT_TWISTED: assert property (ce_i && !state.ctl.force_attachment_port && !state.ctl.auto_port_select
                                     |=> twisted_port_sel_o && !attach_port_sel_o)
    else $error("both bits clear did not select twisted pair");
  AST_PORT_AUTO: assert property (ce_i && !state.ctl.force_attachment_port && state.ctl.auto_port_select
                                  |=> twisted_port_sel_o == $past(link_pulses_ok_i)
                                      && attach_port_sel_o == !$past(link_pulses_ok_i))
    else $error("auto bit did not follow the link state");
  // a frozen clock enable keeps the old output, so only running cycles are judged
  AST_NO_LINK_TX: assert property (ce_i && !link_pulses_ok_i && !link_test_disable_i |=> !twisted_tx_active_o)
    else $error("twisted pair transmitter active without link");
  AST_POL_DISABLED: assert property (ce_i && state.ctl.polarity_fix_disable |=> !polarity_invert_o)
    else $error("polarity corrected while disabled");
  AST_RESET_VALUE: assert property ($rose(rst_n_i) |-> state.ctl == line_control_pkg::LINE_CONTROL_RESET)
    else $error("line control reset value wrong");

  COV_RX_DISABLE_MID: cover property (rx_pass_o && !state.ctl.receive_enable_bit);
  COV_TX_FRAME: cover property ($rose(tx_pass_o));
  COV_AUTO_ATTACH: cover property (port_mode == line_control_pkg::PORT_AUTO && attach_port_sel_o);

endmodule : ethernet_line_control
`default_nettype wire

//--- sim/medium_model.sv
// medium side model: delivers received frames of fixed length
`timescale 1ns/10ps
`default_nettype none
module medium_model #(parameter int unsigned LEN = 12) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // frame request from the bench
  input wire logic start_i,
  // line side
  output logic frame_o
);
  logic [4:0] cnt;
  // a frame on the wire is never cut short, whatever the register does meanwhile
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) cnt <= 5'h00;
    else if (start_i) cnt <= 5'(LEN);
    else if (cnt != 5'h00) cnt <= cnt - 5'h01;
  end
  assign frame_o = (cnt != 5'h00);
endmodule : medium_model
`default_nettype wire

//--- sim/tb_top.sv
// self-checking bench of the line control block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam logic [11:0] OFF = line_control_pkg::LINE_CONTROL_OFFSET;
  logic clk_i, rst_n_i, ce_i, start, tx_frame, link_ok, lt_dis, pol_rev;
  line_control_pkg::reg_req_s req;
  logic [15:0] rdata;
  logic rx_frame, rx_pass, tx_pass, att, tw, twtx, pinv, lsq, tsd, mbo;
  int num_errors = 0;
  int num_checks = 0;
  medium_model #(.LEN(12)) u_medium_model (.clk_i(clk_i), .rst_n_i(rst_n_i), .start_i(start), .frame_o(rx_frame));
  ethernet_line_control u_ethernet_line_control (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .reg_req_i(req), .reg_rdata_o(rdata), .rx_frame_i(rx_frame), .rx_pass_o(rx_pass),
    .tx_frame_i(tx_frame), .tx_pass_o(tx_pass), .link_pulses_ok_i(link_ok), .link_test_disable_i(lt_dis),
    .rx_polarity_reversed_i(pol_rev), .attach_port_sel_o(att), .twisted_port_sel_o(tw),
    .twisted_tx_active_o(twtx), .polarity_invert_o(pinv), .low_squelch_o(lsq),
    .two_stage_defer_disable_o(tsd), .modified_backoff_o(mbo));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk_i);
    req <= '{1'b0, 1'b1, a, d};
    @(posedge clk_i);
    req <= '{1'b0, 1'b0, a, d};
    #1;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [15:0] q);
    @(posedge clk_i);
    req <= '{1'b1, 1'b0, a, 16'h0000};
    @(posedge clk_i);
    req <= '{1'b0, 1'b0, a, 16'h0000};
    #1;
    q = rdata;
  endtask : rd
  function automatic logic [15:0] pv(input logic tx);
    return {15'h0000, tx ? tx_pass : rx_pass};
  endfunction : pv
  task automatic frame_on(input logic tx);
    @(posedge clk_i);
    if (tx) tx_frame <= 1'b1;
    else start <= 1'b1;
    @(posedge clk_i);
    start <= 1'b0;
    #1;
  endtask : frame_on
  // received frames end on their own; a bounded wait keeps a stuck frame from hanging the run
  task automatic frame_off();
    int n;
    n = 0;
    @(posedge clk_i);
    tx_frame <= 1'b0;
    #1;
    while (rx_frame && n < 20) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (rx_frame) begin
      num_errors++;
      print_verdict();
    end
  endtask : frame_off
  task automatic t_reset();
    logic [15:0] q;
    rd(OFF, q);
    chk(q, line_control_pkg::LINE_CONTROL_RESET);
    chk({14'h0000, att, tw}, 16'h0001);
  endtask : t_reset
  task automatic t_reg();
    logic [15:0] q;
    wr(OFF, 16'hffff);
    rd(OFF, q);
    chk(q, 16'h7bd3);
    chk({11'h000, lsq, tsd, mbo, att, tw}, 16'h001e);
    wr(12'h114, 16'h0000);
    rd(OFF, q);
    chk(q, 16'h7bd3);
    rd(12'h114, q);
    chk(q, line_control_pkg::UNMAPPED_READ);
    wr(OFF, 16'h0000);
    rd(OFF, q);
    chk(q, 16'h0013);
  endtask : t_reg
  // clock enable low must drop both the write and the read answer
  task automatic t_freeze();
    logic [15:0] q;
    rd(12'h114, q);
    chk(q, line_control_pkg::UNMAPPED_READ);
    @(posedge clk_i);
    ce_i <= 1'b0;
    wr(OFF, 16'h00c0);
    rd(OFF, q);
    chk(q, line_control_pkg::UNMAPPED_READ);
    @(posedge clk_i);
    ce_i <= 1'b1;
    rd(OFF, q);
    chk(q, line_control_pkg::LINE_CONTROL_RESET);
  endtask : t_freeze
  // every port code against link present or not, link test off or on
  task automatic t_ports();
    logic a;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_i);
      link_ok <= i[2];
      lt_dis <= i[3];
      pol_rev <= i[0] ^ i[2];
      wr(OFF, {3'h0, i[3], 2'h0, i[1], i[0], 8'h00});
      repeat (2) @(posedge clk_i);
      #1;
      a = i[0] | (i[1] & ~i[2]);
      chk({12'h000, att, tw, twtx, pinv}, {12'h000, a, ~a, ~a & (i[2] | i[3]), ~a & (i[0] ^ i[2]) & ~i[3]});
    end
  endtask : t_ports
  task automatic t_gate(input logic tx);
    logic [15:0] en;
    en = tx ? 16'h0080 : 16'h0040;
    wr(OFF, en);
    frame_on(tx);
    chk(pv(tx), 16'h0001);
    wr(OFF, 16'h0000);
    chk(pv(tx), 16'h0001);
    frame_off();
    chk(pv(tx), 16'h0000);
    frame_on(tx);
    wr(OFF, en);
    chk(pv(tx), 16'h0000);
    frame_off();
    frame_on(tx);
    chk(pv(tx), 16'h0001);
    frame_off();
  endtask : t_gate
  initial begin
    rst_n_i = 1'b0;
    ce_i = 1'b1;
    start = 1'b0;
    tx_frame = 1'b0;
    link_ok = 1'b0;
    lt_dis = 1'b0;
    pol_rev = 1'b0;
    req = '0;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_reg();
    t_freeze();
    t_ports();
    t_gate(1'b0);
    t_gate(1'b1);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
